/* common/usart_clock_frame_pkg.sv */
// Constants, register map and state encoding of the serial clock and frame core.
// Assumes one system clock; software reaches the registers over a plain strobe port.
// Summary of operation
// - Four clock modes: normal async, double speed async, sync master, sync slave.
// - In sync mode the clock pin direction picks master (output) or slave (input).
// - Transfer clock pin is used only in sync mode: driven as master, read as slave.
// - Baud down-counter reloads at zero or on low divisor write; ticks at zero.
// - Transmit bit clock is tick divided by 16, 8 or 2 per mode.
// - Async receiver recovery runs on the tick with 16 or 8 states per mode; sync mode samples on the clock edge.
// - Baud divisor is 12 bits from high and low registers, 0 to 4095.
// - Double speed acts only in async mode; the core masks it off in sync.
// - Double speed receiver uses 8 samples per bit instead of 16.
// - Slave clock passes two sync registers and an edge detector, two clocks late.
// - Sync mode samples input on the edge opposite to output change.
// - Polarity clear: change on rising, sample on falling; set swaps the edges.
// - Thirty formats: 5-9 data bits, none/even/odd parity, 1 or 2 stops.
// - Frame order: start, data LSB first, optional parity, stop bits.
// - Start bit low, stop bits high, idle line high.
// - Next frame may follow the last stop bit at once, or the line idles.
// - 3-bit size field, 2-bit parity field, one stop select bit.
// - Receiver checks only the first stop bit.
// - Transmitter and receiver share one frame format setting.
// - Frame error only when the first stop bit samples zero.
// - Parity is XOR of data bits, inverted for odd parity.
// - Size value 7 means 9 bits; ninth transmit bit from a control bit.
package usart_clock_frame_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int BAUD_W = 12;
    localparam logic [ADDR_W-1:0] OFF_CTRL_A = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_CTRL_B = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_CTRL_C = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_BAUD_LO = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_BAUD_HI = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_DATA = 3'h5;
    // Control/status A
    localparam int A_DOUBLE_SPEED = 0;
    localparam int A_FRAME_ERROR = 1;
    localparam int A_PARITY_ERROR = 2;
    localparam int A_RX_READY = 3;
    localparam int A_TX_BUSY = 4;
    // Control/status B
    localparam int B_TX_NINTH = 0;
    localparam int B_RX_NINTH = 1;
    localparam int B_CLK_DIR = 2;
    // Control/status C
    localparam int C_POLARITY = 0;
    localparam int C_SIZE_LO = 1;
    localparam int C_STOP_SEL = 4;
    localparam int C_PARITY_LO = 5;
    localparam int C_SYNC_MODE = 7;
    localparam logic [DATA_W-1:0] CTRL_A_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_B_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_C_RESET = 8'h06;
    localparam logic [3:0] SAMPLES_NORMAL = 4'hF;
    localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [1:0] PARITY_EVEN = 2'h2;
    localparam logic [1:0] PARITY_ODD = 2'h3;

    typedef enum logic [2:0] {
        FR_IDLE = 3'b000,
        FR_START = 3'b001,
        FR_DATA = 3'b011,
        FR_PARITY = 3'b010,
        FR_STOP = 3'b110
    } frame_state_t;
endpackage

/* core/usart_clock_frame_core.sv */
// Baud generator, transfer clock logic, transmit and receive frame engines.
// Assumes pins and register strobes are synchronous to core_clk.
module usart_clock_frame_core #(
    parameter int BAUD_WIDTH = usart_clock_frame_pkg::BAUD_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [usart_clock_frame_pkg::ADDR_W-1:0] regAddr,
    input wire logic [usart_clock_frame_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [usart_clock_frame_pkg::DATA_W-1:0] regRdData,
    output logic serialOutPin,
    input wire logic serialInPin,
    input wire logic transferClockPinIn,
    output logic transferClockPinOut,
    output logic transferClockPinOe
);
    import usart_clock_frame_pkg::*;

    if (BAUD_WIDTH < 9 || BAUD_WIDTH > 16) begin : g_width_check
        $error("BAUD_WIDTH must lie in 9..16");
    end

    function automatic logic [3:0] dataBits(input logic [2:0] size);
        dataBits = (size == SIZE_NINE) ? 4'h9 : (4'h5 + {2'b00, size[1:0]});
    endfunction

    function automatic logic parityOf(input logic [8:0] d, input logic [2:0] size, input logic odd);
        logic [8:0] mask;
        mask = 9'h1FF >> (4'h9 - dataBits(size));
        parityOf = (^(d & mask)) ^ odd;
    endfunction

    // Configuration registers
    logic [DATA_W-1:0] ctrlA_reg, ctrlA_next, ctrlB_reg, ctrlB_next, ctrlC_reg, ctrlC_next;
    logic [BAUD_WIDTH-1:0] baudDivisor_reg, baudDivisor_next;
    logic [DATA_W-1:0] txHold_reg, txHold_next;
    logic txPending_reg, txPending_next;
    logic wrLow, wrData, rdData;

    assign wrLow = regWrite && regAddr == OFF_BAUD_LO;
    assign wrData = regWrite && regAddr == OFF_DATA;
    assign rdData = regRead && regAddr == OFF_DATA;

    // Shared format fields, one copy for both directions
    logic syncMode, clockDir, polarity, twoStops, parityOn, parityOdd, doubleSpeed, masterMode, slaveMode;
    logic [2:0] charSize;
    assign syncMode = ctrlC_reg[C_SYNC_MODE];
    assign clockDir = ctrlB_reg[B_CLK_DIR];
    assign masterMode = syncMode && clockDir;
    assign slaveMode = syncMode && !clockDir;
    assign polarity = ctrlC_reg[C_POLARITY];
    assign charSize = ctrlC_reg[C_SIZE_LO +: 3];
    assign twoStops = ctrlC_reg[C_STOP_SEL];
    assign parityOn = ctrlC_reg[C_PARITY_LO +: 2] == PARITY_EVEN || ctrlC_reg[C_PARITY_LO +: 2] == PARITY_ODD;
    assign parityOdd = ctrlC_reg[C_PARITY_LO +: 2] == PARITY_ODD;
    assign doubleSpeed = ctrlA_reg[A_DOUBLE_SPEED] && !syncMode;

    logic txStart;
    frame_state_t txState_reg, rxState_reg;
    logic rxDone;

    always_comb begin
        ctrlA_next = ctrlA_reg;
        ctrlB_next = ctrlB_reg;
        ctrlC_next = ctrlC_reg;
        baudDivisor_next = baudDivisor_reg;
        txHold_next = txHold_reg;
        txPending_next = txPending_reg && !txStart;
        if (regWrite) begin
            case (regAddr)
                OFF_CTRL_A: ctrlA_next[A_DOUBLE_SPEED] = regWrData[A_DOUBLE_SPEED];
                OFF_CTRL_B: begin
                    ctrlB_next[B_TX_NINTH] = regWrData[B_TX_NINTH];
                    ctrlB_next[B_CLK_DIR] = regWrData[B_CLK_DIR];
                end
                OFF_CTRL_C: ctrlC_next = regWrData;
                OFF_BAUD_LO: baudDivisor_next[7:0] = regWrData;
                OFF_BAUD_HI: baudDivisor_next[BAUD_WIDTH-1:8] = regWrData[BAUD_WIDTH-9:0];
                OFF_DATA: begin
                    txHold_next = regWrData;
                    txPending_next = 1'b1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrlA_reg <= CTRL_A_RESET;
            ctrlB_reg <= CTRL_B_RESET;
            ctrlC_reg <= CTRL_C_RESET;
            baudDivisor_reg <= '0;
            txHold_reg <= '0;
            txPending_reg <= 1'b0;
        end else begin
            ctrlA_reg <= ctrlA_next;
            ctrlB_reg <= ctrlB_next;
            ctrlC_reg <= ctrlC_next;
            baudDivisor_reg <= baudDivisor_next;
            txHold_reg <= txHold_next;
            txPending_reg <= txPending_next;
        end
    end

    // Baud generator and transfer clock
    logic [BAUD_WIDTH-1:0] baudCnt_reg, baudCnt_next;
    logic baudTick;
    logic xckOut_reg, xckOut_next, xckSync1_reg, xckSync2_reg, xckPrev_reg, xckLevel;
    logic [3:0] txDiv_reg, txDiv_next, samplesTop;
    logic rise, fall, changeEdge, sampleEdge, txStrobe;

    assign baudTick = baudCnt_reg == '0;
    assign samplesTop = doubleSpeed ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
    assign xckLevel = masterMode ? xckOut_reg : xckSync2_reg;
    assign rise = xckLevel && !xckPrev_reg;
    assign fall = !xckLevel && xckPrev_reg;
    assign changeEdge = polarity ? fall : rise;
    assign sampleEdge = polarity ? rise : fall;
    assign txStrobe = syncMode ? changeEdge : (baudTick && txDiv_reg == samplesTop);

    always_comb begin
        baudCnt_next = (baudTick || wrLow) ? baudDivisor_next : baudCnt_reg - 1'b1;
        xckOut_next = masterMode ? (xckOut_reg ^ baudTick) : 1'b0;
        txDiv_next = txDiv_reg;
        if (baudTick) begin
            txDiv_next = (txDiv_reg >= samplesTop) ? 4'h0 : txDiv_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            baudCnt_reg <= '0;
            xckOut_reg <= 1'b0;
            xckSync1_reg <= 1'b0;
            xckSync2_reg <= 1'b0;
            xckPrev_reg <= 1'b0;
            txDiv_reg <= 4'h0;
        end else begin
            baudCnt_reg <= baudCnt_next;
            xckOut_reg <= xckOut_next;
            xckSync1_reg <= transferClockPinIn;
            xckSync2_reg <= xckSync1_reg;
            xckPrev_reg <= xckLevel;
            txDiv_reg <= txDiv_next;
        end
    end

    assign transferClockPinOut = xckOut_reg;
    assign transferClockPinOe = masterMode;

    // Transmitter
    frame_state_t txState_next;
    logic [8:0] txShift_reg, txShift_next;
    logic [3:0] txIdx_reg, txIdx_next;
    logic txStopIdx_reg, txStopIdx_next, txLine_reg, txLine_next;

    always_comb begin
        txState_next = txState_reg;
        txShift_next = txShift_reg;
        txIdx_next = txIdx_reg;
        txStopIdx_next = txStopIdx_reg;
        txLine_next = txLine_reg;
        txStart = 1'b0;
        if (txStrobe) begin
            case (txState_reg)
                FR_IDLE: begin
                    txLine_next = 1'b1;
                    if (txPending_reg) begin
                        txStart = 1'b1;
                    end
                end
                FR_START: begin
                    txState_next = FR_DATA;
                    txIdx_next = 4'h0;
                    txLine_next = txShift_reg[0];
                end
                FR_DATA: begin
                    if (txIdx_reg == dataBits(charSize) - 4'h1) begin
                        txState_next = parityOn ? FR_PARITY : FR_STOP;
                        txStopIdx_next = 1'b0;
                        txLine_next = parityOn ? parityOf(txShift_reg, charSize, parityOdd) : 1'b1;
                    end else begin
                        txIdx_next = txIdx_reg + 4'h1;
                        txLine_next = txShift_reg[txIdx_next];
                    end
                end
                FR_PARITY: begin
                    txState_next = FR_STOP;
                    txLine_next = 1'b1;
                end
                FR_STOP: begin
                    if (!txStopIdx_reg && twoStops) begin
                        txStopIdx_next = 1'b1;
                    end else if (txPending_reg) begin
                        txStart = 1'b1;
                    end else begin
                        txState_next = FR_IDLE;
                    end
                end
                default: begin
                    txState_next = FR_IDLE;
                    txLine_next = 1'b1;
                end
            endcase
            if (txStart) begin
                txState_next = FR_START;
                txShift_next = {ctrlB_reg[B_TX_NINTH], txHold_reg};
                txLine_next = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            txState_reg <= FR_IDLE;
            txShift_reg <= '0;
            txIdx_reg <= 4'h0;
            txStopIdx_reg <= 1'b0;
            txLine_reg <= 1'b1;
        end else begin
            txState_reg <= txState_next;
            txShift_reg <= txShift_next;
            txIdx_reg <= txIdx_next;
            txStopIdx_reg <= txStopIdx_next;
            txLine_reg <= txLine_next;
        end
    end

    assign serialOutPin = txLine_reg;

    // Receiver
    frame_state_t rxState_next;
    logic [8:0] rxShift_reg, rxShift_next, rxWord_reg, rxWord_next;
    logic [3:0] rxIdx_reg, rxIdx_next, rxPhase_reg, rxPhase_next;
    logic rxReady_reg, rxReady_next, frameErr_reg, frameErr_next, parErr_reg, parErr_next;
    logic parSeen_reg, parSeen_next, rxSample, startSeen;

    assign rxSample = syncMode ? sampleEdge
        : (baudTick && rxPhase_reg == (samplesTop >> 1) && rxState_reg != FR_IDLE);
    assign startSeen = syncMode ? (sampleEdge && !serialInPin) : (baudTick && !serialInPin);

    always_comb begin
        rxState_next = rxState_reg;
        rxShift_next = rxShift_reg;
        rxWord_next = rxWord_reg;
        rxIdx_next = rxIdx_reg;
        rxPhase_next = rxPhase_reg;
        frameErr_next = frameErr_reg;
        parErr_next = parErr_reg;
        parSeen_next = parSeen_reg;
        rxDone = 1'b0;
        if (baudTick && rxState_reg != FR_IDLE) begin
            rxPhase_next = (rxPhase_reg >= samplesTop) ? 4'h0 : rxPhase_reg + 4'h1;
        end
        case (rxState_reg)
            FR_IDLE: begin
                if (startSeen) begin
                    rxState_next = syncMode ? FR_DATA : FR_START;
                    rxPhase_next = 4'h0;
                    rxIdx_next = 4'h0;
                    rxShift_next = '0;
                end
            end
            FR_START: begin
                if (rxSample) begin
                    rxState_next = serialInPin ? FR_IDLE : FR_DATA;
                end
            end
            FR_DATA: begin
                if (rxSample) begin
                    rxShift_next[rxIdx_reg] = serialInPin;
                    rxIdx_next = rxIdx_reg + 4'h1;
                    if (rxIdx_reg == dataBits(charSize) - 4'h1) begin
                        rxState_next = parityOn ? FR_PARITY : FR_STOP;
                        parSeen_next = 1'b0;
                    end
                end
            end
            FR_PARITY: begin
                if (rxSample) begin
                    parSeen_next = serialInPin != parityOf(rxShift_reg, charSize, parityOdd);
                    rxState_next = FR_STOP;
                end
            end
            FR_STOP: begin
                if (rxSample) begin
                    frameErr_next = !serialInPin;
                    parErr_next = parSeen_reg;
                    rxWord_next = rxShift_reg;
                    rxDone = 1'b1;
                    rxState_next = FR_IDLE;
                end
            end
            default: rxState_next = FR_IDLE;
        endcase
        // A word landing in the same cycle as a read keeps ready set
        rxReady_next = rxDone || (rxReady_reg && !rdData);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rxState_reg <= FR_IDLE;
            rxShift_reg <= '0;
            rxWord_reg <= '0;
            rxIdx_reg <= 4'h0;
            rxPhase_reg <= 4'h0;
            rxReady_reg <= 1'b0;
            frameErr_reg <= 1'b0;
            parErr_reg <= 1'b0;
            parSeen_reg <= 1'b0;
        end else begin
            rxState_reg <= rxState_next;
            rxShift_reg <= rxShift_next;
            rxWord_reg <= rxWord_next;
            rxIdx_reg <= rxIdx_next;
            rxPhase_reg <= rxPhase_next;
            rxReady_reg <= rxReady_next;
            frameErr_reg <= frameErr_next;
            parErr_reg <= parErr_next;
            parSeen_reg <= parSeen_next;
        end
    end

    // Read port
    logic [DATA_W-1:0] rdData_reg, rdData_next;
    always_comb begin
        rdData_next = '0;
        if (regRead) begin
            case (regAddr)
                OFF_CTRL_A: begin
                    rdData_next[A_DOUBLE_SPEED] = ctrlA_reg[A_DOUBLE_SPEED];
                    rdData_next[A_FRAME_ERROR] = frameErr_reg;
                    rdData_next[A_PARITY_ERROR] = parErr_reg;
                    rdData_next[A_RX_READY] = rxReady_reg;
                    rdData_next[A_TX_BUSY] = txPending_reg || txState_reg != FR_IDLE;
                end
                OFF_CTRL_B: begin
                    rdData_next = ctrlB_reg;
                    rdData_next[B_RX_NINTH] = rxWord_reg[8];
                end
                OFF_CTRL_C: rdData_next = ctrlC_reg;
                OFF_BAUD_LO: rdData_next = baudDivisor_reg[7:0];
                OFF_BAUD_HI: rdData_next[BAUD_WIDTH-9:0] = baudDivisor_reg[BAUD_WIDTH-1:8];
                OFF_DATA: rdData_next = rxWord_reg[7:0];
                default: rdData_next = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdData_reg <= '0;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;

    a_baud_reload: assert property (@(posedge core_clk) disable iff (!nrst)
        (baudTick && !wrLow && !regWrite) |=> baudCnt_reg == $past(baudDivisor_reg))
        else $error("baud counter did not reload at zero");
    a_low_write_reload: assert property (@(posedge core_clk) disable iff (!nrst)
        wrLow |=> baudCnt_reg == baudDivisor_reg)
        else $error("low divisor write did not reload counter");
    a_idle_high: assert property (@(posedge core_clk) disable iff (!nrst)
        (txState_reg == FR_IDLE || txState_reg == FR_STOP) |-> serialOutPin)
        else $error("line not high when idle or stop");
    a_start_low: assert property (@(posedge core_clk) disable iff (!nrst)
        txState_reg == FR_START |-> !serialOutPin)
        else $error("start bit not low");
    a_master_toggle: assert property (@(posedge core_clk) disable iff (!nrst)
        (masterMode && baudTick && !regWrite) |=> transferClockPinOut != $past(transferClockPinOut))
        else $error("master clock not toggling on tick");
    a_pin_unused_async: assert property (@(posedge core_clk) disable iff (!nrst)
        !syncMode |-> !transferClockPinOe)
        else $error("clock pin driven in async mode");
    a_slave_delay: assert property (@(posedge core_clk) disable iff (!nrst)
        (slaveMode && !$past(masterMode) && ($past(transferClockPinIn, 2) ^ polarity)
            && !($past(transferClockPinIn, 3) ^ polarity)) |-> txStrobe)
        else $error("slave edge not seen two clocks after pin");
    a_frame_error: assert property (@(posedge core_clk) disable iff (!nrst)
        (rxState_reg == FR_STOP && rxSample) |=> frameErr_reg == !$past(serialInPin))
        else $error("frame error does not follow first stop bit");
    a_double_async: assert property (@(posedge core_clk) disable iff (!nrst)
        syncMode |-> samplesTop == SAMPLES_NORMAL)
        else $error("double speed active in sync mode");
    a_parity_out: assert property (@(posedge core_clk) disable iff (!nrst)
        txState_reg == FR_PARITY |-> serialOutPin == parityOf(txShift_reg, charSize, parityOdd))
        else $error("parity bit wrong");
endmodule // usart_clock_frame_core

/* verif/remote_serial_peer.sv */
// Far-end serial transmitter feeding the core's receive line and its slave transfer clock.
// Assumes the caller enters send right after a rising clock edge.
module remote_serial_peer (
    input wire logic clk,
    output logic line,
    output logic xferClk
);
    timeunit 1ns;
    timeprecision 1ps;

    initial line = 1'b1;
    initial xferClk = 1'b0;

    // Frame bits are sent in index order, so the caller lays out start, data, parity, stops
    task automatic send(input logic [12:0] f, input int len, input int per);
        for (int i = 0; i < len; i++) begin
            line <= f[i];
            repeat (per) @(posedge clk);
        end
        line <= 1'b1;
    endtask

    // Data moves on the change edge so the core's sample edge sees it settled
    task automatic sendSync(input logic [12:0] f, input int len, input int half, input logic pol);
        xferClk <= pol;
        repeat (half) @(posedge clk);
        for (int i = 0; i < len; i++) begin
            xferClk <= !pol;
            line <= f[i];
            repeat (half) @(posedge clk);
            xferClk <= pol;
            repeat (half) @(posedge clk);
        end
        line <= 1'b1;
    endtask
endmodule // remote_serial_peer

/* verif/tb_usart_clock_and_frame_core.sv */
// Self-checking bench of the serial clock and frame core.
// Assumes divisor values stay small so every frame is a few hundred clocks.
module tb_usart_clock_and_frame_core;
    import usart_clock_frame_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic serialOutPin, serialInPin, transferClockPinOut, transferClockPinOe;
    logic rdPend = 1'b0;
    logic [7:0] rdQ[$];
    logic [12:0] txQ[$];
    logic [12:0] got, f;
    logic [8:0] d;
    logic [2:0] sz;
    logic [1:0] pm;
    logic ds, prevClk, txNinth, xferClk;
    int numErrors = 0, checked = 0, cyc = 0, bitClk = 16, txLen = 10, n, dv, tgl;
    int szTab[6] = '{0, 1, 2, 3, 7, 3};
    int pmTab[6] = '{0, 2, 3, 2, 3, 0};

    usart_clock_frame_core dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .serialOutPin(serialOutPin),
        .serialInPin(serialInPin), .transferClockPinIn(xferClk), .transferClockPinOut(transferClockPinOut),
        .transferClockPinOe(transferClockPinOe));
    remote_serial_peer peer (.clk(core_clk), .line(serialInPin), .xferClk(xferClk));

    initial forever #12.5 core_clk = ~core_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("errors=%0d checks=%0d", numErrors, checked);
        if (numErrors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        rdQ.push_back(exp);
        @(posedge core_clk);
        regRead <= 1'b0;
        @(posedge core_clk);
    endtask

    // Start bit, data LSB first, optional parity, stop ones above
    function automatic logic [12:0] mkFrame(input logic [8:0] v, input int nb, input logic [1:0] pmode);
        logic [12:0] fr;
        fr = '1;
        fr[0] = 1'b0;
        for (int i = 0; i < nb; i++) fr[i+1] = v[i];
        if (pmode[1]) fr[nb+1] = ^(v & ((9'h1 << nb) - 9'h1)) ^ (pmode == PARITY_ODD);
        return fr;
    endfunction

    always @(posedge core_clk) begin
        if (rdPend) check(16'(regRdData), 16'(rdQ.pop_front()));
        rdPend <= regRead;
        cyc++;
        if (cyc == 40000) begin
            numErrors++;
            print_verdict;
        end
    end

    // Mid-bit sampling; no wait after the last stop so a back-to-back start is caught
    always begin
        @(negedge serialOutPin);
        repeat (bitClk / 2) @(posedge core_clk);
        for (int i = 0; i < txLen; i++) begin
            got[i] = serialOutPin;
            if (i < txLen - 1) repeat (bitClk) @(posedge core_clk);
        end
        f = txQ.pop_front();
        check(16'(got & ((13'h1 << txLen) - 1)), 16'(f & ((13'h1 << txLen) - 1)));
    end

    initial begin
        void'($urandom(71547));
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd(OFF_CTRL_A, CTRL_A_RESET);
        rd(OFF_CTRL_B, CTRL_B_RESET);
        rd(OFF_CTRL_C, CTRL_C_RESET);
        wr(3'h6, 8'hA5);
        rd(3'h6, 8'h00);
        wr(OFF_CTRL_A, 8'hFE);
        rd(OFF_CTRL_A, 8'h00);
        for (int k = 0; k < 6; k++) begin
            sz = 3'(szTab[k]);
            pm = 2'(pmTab[k]);
            ds = (k == 2 || k == 5);
            dv = k % 3;
            n = (sz == SIZE_NINE) ? 9 : sz + 5;
            bitClk = (dv + 1) * (ds ? 8 : 16);
            txLen = n + 2 + pm[1] + k % 2;
            d = 9'($urandom);
            wr(OFF_CTRL_A, {7'h0, ds});
            wr(OFF_CTRL_B, {7'h0, d[8]});
            txNinth = d[8];
            wr(OFF_CTRL_C, {1'b0, pm, 1'(k % 2), sz, 1'b0});
            wr(OFF_BAUD_HI, 8'h00);
            wr(OFF_BAUD_LO, 8'(dv));
            txQ.push_back(mkFrame(d, n, pm));
            wr(OFF_DATA, d[7:0]);
            if (k == 3) begin
                // Second byte held during the first frame goes out with no idle gap
                repeat (2 * bitClk) @(posedge core_clk);
                d = 9'($urandom);
                txQ.push_back(mkFrame(d, n, pm));
                wr(OFF_DATA, d[7:0]);
            end
            repeat ((2 * txLen + 2) * bitClk) @(posedge core_clk);
            d = 9'($urandom);
            f = mkFrame(d, n, pm);
            if (k == 4) f[n+1+pm[1]] = 1'b0;
            peer.send(f, txLen, bitClk);
            repeat (bitClk) @(posedge core_clk);
            rd(OFF_CTRL_A, {4'h0, 1'b1, 1'b0, k == 4, ds});
            rd(OFF_DATA, 8'(d & ((9'h1 << n) - 9'h1)));
            if (sz == SIZE_NINE) rd(OFF_CTRL_B, {6'h0, d[8], txNinth});
        end
        wr(OFF_CTRL_A, 8'h00);
        // Slave frames both ways on the peer's clock, once per polarity
        bitClk = 8;
        txLen = 10;
        wr(OFF_CTRL_B, 8'h00);
        for (int p = 0; p < 2; p++) begin
            wr(OFF_CTRL_C, {7'h43, 1'(p)});
            d = 9'($urandom);
            txQ.push_back(mkFrame(d, 8, 2'h0));
            wr(OFF_DATA, d[7:0]);
            d = 9'($urandom);
            peer.sendSync(mkFrame(d, 8, 2'h0), 11, 4, 1'(p));
            repeat (8) @(posedge core_clk);
            rd(OFF_CTRL_A, 8'h08);
            rd(OFF_DATA, d[7:0]);
        end
        wr(OFF_BAUD_LO, 8'h00);
        wr(OFF_CTRL_B, 8'h04);
        wr(OFF_CTRL_C, 8'h86);
        repeat (4) @(posedge core_clk);
        check(16'(transferClockPinOe), 16'h0001);
        prevClk = transferClockPinOut;
        tgl = 0;
        repeat (16) begin
            @(posedge core_clk);
            if (transferClockPinOut !== prevClk) tgl++;
            prevClk = transferClockPinOut;
        end
        check(16'(tgl), 16'h0010);
        wr(OFF_CTRL_C, 8'h06);
        repeat (4) @(posedge core_clk);
        check(16'({transferClockPinOe, transferClockPinOut}), 16'h0000);
        repeat (4) @(posedge core_clk);
        // A frame that never left the core would otherwise go unnoticed
        check(16'(txQ.size()), 16'h0000);
        print_verdict;
    end
endmodule // tb_usart_clock_and_frame_core
